/* dio_group_ctrl.sv */
// Contract
// - per-group choice of auto or commanded re-arm
// - auto re-arm every ten seconds while tripped
// - commanded re-arm, ten seconds minimum spacing
// - re-arm clears only tripped channels of group
// - fallback on bus fault or processor stop
// - per group hold last or go fallback
// - each channel has its own fallback level
// - groups are eight channels from multiples
// - modes and shared functions common per group
// - filter 0.1 ms to 7.5 ms, 0.5 ms steps
// - filter defaults to 4 ms
// - latch short pulse until next scan; the code latches only edges of the filtered input
// - latch set by configured edge direction
// - sixteen event inputs raise top-priority interrupt
// - event zero belongs to channel zero
// - rise, fall or both, edge type reported
// - simultaneous events presented lowest channel first
// - four-by-four contact network per output
// - overload on active output trips and reports
`timescale 1ns/100ps
`include "dio_defines.svh"

module dio_group_ctrl #(
  parameter int NCH           = 16,
  parameter int NEVT          = 16,
  parameter int REARM_CYC     = `DIO_REARM_CYC,
  parameter int FILT_MIN_CYC  = `DIO_FILT_MIN_CYC,
  parameter int FILT_STEP_CYC = `DIO_FILT_STEP_CYC,
  parameter int NGRP          = NCH / `DIO_GRP_SIZE,
  parameter int EW            = (NEVT > 1) ? $clog2(NEVT) : 1,
  parameter int SW            = $clog2(4 * NCH),
  parameter int RCW           = `DIO_RFX_ROWS * `DIO_RFX_COLS * (SW + 2)
) (
  input  wire logic                   core_clk_in,
  input  wire logic                   srst_in,
  input  wire logic [NCH-1:0]         raw_in,
  input  wire logic [NCH-1:0]         out_cmd_in,
  input  wire logic [NCH-1:0]         overload_in,
  input  wire logic [NGRP-1:0]        rearm_auto_in,
  input  wire logic [NGRP-1:0]        rearm_req_in,
  input  wire logic                   bus_fault_in,
  input  wire logic                   cpu_stop_in,
  input  wire logic [NGRP-1:0]        fb_mode_in,
  input  wire logic [NCH-1:0]         fb_val_in,
  input  wire logic                   cfg_default_in,
  input  wire logic                   cfg_load_in,
  input  wire logic [3:0]             filt_code_in,
  input  wire logic [NCH-1:0]         latch_en_in,
  input  wire logic [NCH-1:0]         latch_rise_in,
  input  wire logic                   scan_read_in,
  input  wire logic [NEVT-1:0]        evt_en_in,
  input  wire logic [2*NEVT-1:0]      evt_edge_in,
  input  wire logic                   evt_ack_in,
  input  wire logic [NCH-1:0]         reflex_en_in,
  input  wire logic [NCH*RCW-1:0]     reflex_cfg_in,
  output logic      [NCH-1:0]         out_drive_out,
  output logic      [NCH-1:0]         tripped_out,
  output logic      [NGRP-1:0]        grp_trip_out,
  output logic      [NCH-1:0]         filt_out,
  output logic      [NCH-1:0]         latch_out,
  output logic      [3:0]             filt_code_out,
  output logic                        evt_irq_out,
  output logic      [EW-1:0]          evt_chan_out,
  output logic                        evt_rise_out
);
  import dio_pkg::*;

  localparam int GS  = `DIO_GRP_SIZE;
  localparam int TW  = `DIO_FILT_TW;
  localparam int RW  = $clog2(REARM_CYC + 1);

  // ----------------------------------------------------------------------
  // helpers
  // ----------------------------------------------------------------------
  function automatic logic edge_hit(input dio_edge_type cfg, input logic r, input logic f);
    case (cfg)
      edge_rise:         edge_hit = r;
      edge_fall:         edge_hit = f;
      both_edge_trigger: edge_hit = r | f;
      default:           edge_hit = 1'b0;
    endcase
  endfunction

  function automatic logic [EW-1:0] lowest(input logic [NEVT-1:0] v);
    lowest = '0;
    for (int i = NEVT - 1; i >= 0; i--) begin
      if (v[i]) begin
        lowest = EW'(i);
      end
    end
  endfunction

  logic [NCH-1:0]  trip_q;
  logic [NCH-1:0]  trip_d;
  logic [NCH-1:0]  hold_q;
  logic [NCH-1:0]  val_d;
  logic [NCH-1:0]  drive_d;
  logic [NCH-1:0]  rfx_res;
  logic [NCH-1:0]  trip_cause;
  logic [NCH-1:0]  prev_q;
  logic [NCH-1:0]  rise;
  logic [NCH-1:0]  fall;
  logic [NGRP-1:0] fire;
  logic [NGRP-1:0] done;
  logic [TW-1:0]   thr_q;
  logic            fb_act;

  assign fb_act     = bus_fault_in | cpu_stop_in;
  assign trip_cause = overload_in & out_drive_out;
  assign rise       = filt_out & ~prev_q;
  assign fall       = ~filt_out & prev_q;

  // ----------------------------------------------------------------------
  // re-arm timing, one timer per group
  // ----------------------------------------------------------------------
  // group g owns channels 8g..8g+7
  for (genvar g = 0; g < NGRP; g++) begin : g_grp
    logic [RW-1:0] cnt_q;
    logic          any_trip;

    assign any_trip = |trip_q[g*GS +: GS];
    assign done[g]  = (cnt_q == RW'(REARM_CYC - 1));

    assign fire[g] = rearm_auto_in[g] ? (any_trip & done[g]) : (rearm_req_in[g] & done[g]);

    always_ff @(posedge core_clk_in) begin
      if (srst_in || fire[g]) begin
        cnt_q <= '0;
      end else if (rearm_auto_in[g] && !any_trip) begin
        cnt_q <= '0;
      end else if (!done[g]) begin
        cnt_q <= cnt_q + RW'(1);
      end
    end

    chk_rearm_early: assert property (
      @(posedge core_clk_in) disable iff (srst_in)
      (!rearm_auto_in[g] && rearm_req_in[g] && !done[g]) |=> (cnt_q != '0 || $past(cnt_q) == '0)
    ) else $error("early re-arm request was taken");

    chk_rearm_auto: assert property (
      @(posedge core_clk_in) disable iff (srst_in)
      (rearm_auto_in[g] && any_trip && done[g]) |=> (cnt_q == '0)
    ) else $error("auto re-arm did not fire at period end");

    // hold groups never rise above the frozen state
    chk_fb_hold: assert property (
      @(posedge core_clk_in) disable iff (srst_in)
      (fb_act && !fb_mode_in[g])
        |=> ((out_drive_out[g*GS +: GS] & ~hold_q[g*GS +: GS]) == '0)
    ) else $error("held output rose during fallback");

    // fallback groups never exceed their levels
    chk_fb_level: assert property (
      @(posedge core_clk_in) disable iff (srst_in)
      (fb_act && fb_mode_in[g])
        |=> ((out_drive_out[g*GS +: GS] & ~$past(fb_val_in[g*GS +: GS])) == '0)
    ) else $error("output above its fallback level");
  end

  // ----------------------------------------------------------------------
  // trip and output drive
  // ----------------------------------------------------------------------
  always_comb begin
    trip_d = trip_q;
    val_d  = '0;
    for (int i = 0; i < NCH; i++) begin
      // clear only tripped bits of the fired group
      // new overload wins over a clear
      trip_d[i] = (trip_q[i] & ~fire[i/GS]) | trip_cause[i];
      val_d[i]  = reflex_en_in[i] ? rfx_res[i] : out_cmd_in[i];
      // fallback on bus or processor fault
      if (fb_act) begin
        val_d[i] = fb_mode_in[i/GS] ? fb_val_in[i] : hold_q[i];
      end
    end
    drive_d = val_d & ~trip_d;
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      trip_q <= '0;
    end else begin
      trip_q <= trip_d;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      out_drive_out <= '0;
    end else begin
      out_drive_out <= drive_d;
    end
  end

  // last commanded state, frozen while the fault lasts
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      hold_q <= '0;
    end else if (!fb_act) begin
      hold_q <= val_d;
    end
  end

  assign tripped_out = trip_q;

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      grp_trip_out <= '0;
    end else begin
      for (int g = 0; g < NGRP; g++) begin
        grp_trip_out[g] <= |trip_d[g*GS +: GS];
      end
    end
  end

  // ----------------------------------------------------------------------
  // reflex stage
  // ----------------------------------------------------------------------
  // one network per output
  for (genvar i = 0; i < NCH; i++) begin : g_rfx
    dio_reflex #(
      .NOP (4 * NCH),
      .SW  (SW)
    ) u_rfx (
      .opnd_in    ({out_drive_out, trip_q, out_cmd_in, filt_out}),
      .cfg_in     (reflex_cfg_in[i*RCW +: RCW]),
      .result_out (rfx_res[i])
    );
  end

  // ----------------------------------------------------------------------
  // input filter
  // ----------------------------------------------------------------------
  // defaults restore 4 ms
  always_ff @(posedge core_clk_in) begin
    if (srst_in || cfg_default_in) begin
      filt_code_out <= `DIO_FILT_DEF;
    end else if (cfg_load_in) begin
      filt_code_out <= filt_code_in;
    end
  end

  // code 0 is the shortest time, others step
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      // matches the default code that reset loads
      thr_q <= TW'(FILT_STEP_CYC * int'(`DIO_FILT_DEF));
    end else if (filt_code_out == '0) begin
      thr_q <= TW'(FILT_MIN_CYC);
    end else begin
      thr_q <= TW'(FILT_STEP_CYC * int'(filt_code_out));
    end
  end

  // host keeps the code high enough
  for (genvar i = 0; i < NCH; i++) begin : g_filt
    dio_filt #(
      .TW (TW)
    ) u_filt (
      .core_clk_in (core_clk_in),
      .srst_in     (srst_in),
      .raw_in      (raw_in[i]),
      .thr_in      (thr_q),
      .filt_out    (filt_out[i])
    );
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      prev_q <= '0;
    end else begin
      prev_q <= filt_out;
    end
  end

  // ----------------------------------------------------------------------
  // latching
  // ----------------------------------------------------------------------
  // held until the scan reads it
  // short pulses never pass the filter
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      latch_out <= '0;
    end else begin
      latch_out <= (latch_out & ~{NCH{scan_read_in}})
                 | (latch_en_in & ((latch_rise_in & rise) | (~latch_rise_in & fall)));
    end
  end

  // ----------------------------------------------------------------------
  // events
  // ----------------------------------------------------------------------
  dio_evst_type    ev_st_q;
  logic [NEVT-1:0] pend_q;
  logic [NEVT-1:0] prise_q;
  logic [NEVT-1:0] hit;
  logic [NEVT-1:0] take;
  logic [EW-1:0]   low_idx;

  // event i sits on channel i, so event 0 is channel 0
  always_comb begin
    hit = '0;
    for (int i = 0; i < NEVT; i++) begin
      hit[i] = evt_en_in[i] & edge_hit(dio_edge_type'(evt_edge_in[2*i +: 2]), rise[i], fall[i]);
    end
  end

  assign low_idx = lowest(pend_q);
  assign take    = (ev_st_q == EV_IDLE && |pend_q) ? (NEVT'(1) << low_idx) : '0;

  // the host paces edges, a repeat merges
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      pend_q <= '0;
    end else begin
      pend_q <= (pend_q & ~take) | hit;
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      prise_q <= '0;
    end else begin
      for (int i = 0; i < NEVT; i++) begin
        if (hit[i]) begin
          prise_q[i] <= rise[i];
        end
      end
    end
  end

  // one event at a time to the host
  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      ev_st_q      <= EV_IDLE;
      evt_irq_out  <= 1'b0;
      evt_chan_out <= '0;
      evt_rise_out <= 1'b0;
    end else begin
      case (ev_st_q)
        EV_IDLE: begin
          if (|pend_q) begin
            ev_st_q      <= EV_WAIT;
            evt_irq_out  <= 1'b1;
            evt_chan_out <= low_idx;
            evt_rise_out <= prise_q[low_idx];
          end
        end
        EV_WAIT: begin
          if (evt_ack_in) begin
            ev_st_q     <= EV_IDLE;
            evt_irq_out <= 1'b0;
          end
        end
        default: begin
          ev_st_q     <= EV_IDLE;
          evt_irq_out <= 1'b0;
        end
      endcase
    end
  end

  // ----------------------------------------------------------------------
  // checks
  // ----------------------------------------------------------------------
  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  chk_trip_off: assert property (
    (trip_q & out_drive_out) == '0
  ) else $error("tripped output still driven");

  chk_trip_set: assert property (
    (trip_cause != '0) |=> ((($past(trip_cause)) & ~trip_q) == '0)
  ) else $error("overload did not trip the output");

  chk_filt_default: assert property (
    cfg_default_in |=> (filt_code_out == `DIO_FILT_DEF) ##1 (thr_q == TW'(8 * FILT_STEP_CYC))
  ) else $error("filter default not restored");

  chk_latch_hold: assert property (
    !scan_read_in |=> ((($past(latch_out)) & ~latch_out) == '0)
  ) else $error("latch lost before scan read");

  sequence s_ev_pick;
    ev_st_q == EV_IDLE && pend_q != '0;
  endsequence

  chk_evt_order: assert property (
    s_ev_pick |=> evt_irq_out && evt_chan_out == $past(low_idx)
  ) else $error("event not presented lowest first");

  chk_evt_stand: assert property (
    (evt_irq_out && !evt_ack_in) |=> evt_irq_out && $stable(evt_chan_out)
  ) else $error("event request dropped before ack");

endmodule

/* dio_defines.svh */
`ifndef DIO_DEFINES_SVH
`define DIO_DEFINES_SVH

// ----------------------------------------------------------------------
// timebase
// ----------------------------------------------------------------------
`define DIO_CLK_MHZ        125

// ----------------------------------------------------------------------
// re-arm spacing
// ----------------------------------------------------------------------
`define DIO_REARM_MS       10000
`define DIO_REARM_CYC      (`DIO_REARM_MS * 1000 * `DIO_CLK_MHZ)

// ----------------------------------------------------------------------
// input filter: code 0 is the shortest time, code n>0 is n steps
// ----------------------------------------------------------------------
`define DIO_FILT_MIN_US    100
`define DIO_FILT_STEP_US   500
`define DIO_FILT_MIN_CYC   (`DIO_FILT_MIN_US * `DIO_CLK_MHZ)
`define DIO_FILT_STEP_CYC  (`DIO_FILT_STEP_US * `DIO_CLK_MHZ)
`define DIO_FILT_CW        4
`define DIO_FILT_DEF       4'h8
`define DIO_FILT_TW        20

// ----------------------------------------------------------------------
// reflex network contact layout
// ----------------------------------------------------------------------
`define DIO_RFX_ROWS       4
`define DIO_RFX_COLS       4
`define DIO_CT_EN_OFS      1
`define DIO_CT_INV_OFS     0

// ----------------------------------------------------------------------
// channel grouping
// ----------------------------------------------------------------------
`define DIO_GRP_SIZE       8

`endif

/* dio_pkg.sv */
package dio_pkg;

  typedef enum logic [1:0] {
    edge_rise,
    edge_fall,
    both_edge_trigger
  } dio_edge_type;

  typedef enum logic {
    EV_IDLE,
    EV_WAIT
  } dio_evst_type;

endpackage

/* dio_filt.sv */
`timescale 1ns/100ps
`include "dio_defines.svh"

module dio_filt #(
  parameter int TW = `DIO_FILT_TW
) (
  input  wire logic          core_clk_in,
  input  wire logic          srst_in,
  input  wire logic          raw_in,
  input  wire logic [TW-1:0] thr_in,
  output logic               filt_out
);
  import dio_pkg::*;

  logic [TW-1:0] cnt_q;

  // ----------------------------------------------------------------------
  // stability counter
  // ----------------------------------------------------------------------
  // restart on any bounce
  always_ff @(posedge core_clk_in) begin
    if (srst_in || raw_in == filt_out) begin
      cnt_q <= '0;
    end else if (cnt_q < thr_in - TW'(1)) begin
      cnt_q <= cnt_q + TW'(1);
    end
  end

  always_ff @(posedge core_clk_in) begin
    if (srst_in) begin
      filt_out <= 1'b0;
    end else if (raw_in != filt_out && cnt_q >= thr_in - TW'(1)) begin
      filt_out <= raw_in;
    end
  end

  default clocking cb @(posedge core_clk_in); endclocking
  default disable iff (srst_in);

  chk_filt_settle: assert property (
    $changed(filt_out) |-> $past(cnt_q) >= $past(thr_in) - TW'(1)
  ) else $error("filtered input changed before the filter time");

endmodule

/* dio_reflex.sv */
`timescale 1ns/100ps
`include "dio_defines.svh"

module dio_reflex #(
  parameter int NOP = 64,
  parameter int SW  = 6
) (
  input  wire logic [NOP-1:0]                                   opnd_in,
  input  wire logic [`DIO_RFX_ROWS*`DIO_RFX_COLS*(SW+2)-1:0]    cfg_in,
  output logic                                                  result_out
);
  import dio_pkg::*;

  localparam int CB = SW + 2;

  // ----------------------------------------------------------------------
  // four rows of four series contacts, rows in parallel
  // ----------------------------------------------------------------------
  // combinational rung
  always_comb begin
    logic [CB-1:0] ct;
    logic          row;
    logic          used;
    logic          op;
    ct         = '0;
    row        = 1'b0;
    used       = 1'b0;
    op         = 1'b0;
    result_out = 1'b0;
    for (int r = 0; r < `DIO_RFX_ROWS; r++) begin
      row  = 1'b1;
      used = 1'b0;
      for (int c = 0; c < `DIO_RFX_COLS; c++) begin
        ct = cfg_in[(r*`DIO_RFX_COLS+c)*CB +: CB];
        // out-of-range operand reads as 0, before the invert
        op = (int'(ct[CB-1:2]) < NOP) ? opnd_in[ct[CB-1:2]] : 1'b0;
        if (ct[`DIO_CT_EN_OFS]) begin
          used = 1'b1;
          row  = row & (op ^ ct[`DIO_CT_INV_OFS]);
        end
      end
      // an empty row never conducts
      result_out = result_out | (row & used);
    end
  end

endmodule

/* dio_field_model.sv */
`timescale 1ns/100ps

module dio_field_model #(
  parameter int NCH = 16
) (
  input  wire logic           core_clk_in,
  input  wire logic [NCH-1:0] drive_in,
  input  wire logic [NCH-1:0] short_in,
  input  wire logic [NCH-1:0] level_in,
  output logic      [NCH-1:0] raw_out,
  output logic      [NCH-1:0] overload_out
);
  // sensor contacts settle one cycle after they are moved
  always_ff @(posedge core_clk_in) begin
    raw_out <= level_in;
  end

  assign overload_out = short_in & drive_in;
endmodule

/* dio_group_ctrl_tb.sv */
`timescale 1ns/100ps

module dio_group_ctrl_tb;
  import dio_pkg::*;
  localparam int RC  = 50;
  localparam int RCW = 128;

  logic             core_clk_in = 1'b0;
  logic             srst_in     = 1'b1;
  logic [15:0]      raw, ovl, drive, trip, filt, latch;
  logic [15:0]      level = '0, short_m = '0, out_cmd = '0, fb_val = '0;
  logic [15:0]      latch_en = '0, latch_rise = '0, evt_en = '0, rfx_en = '0;
  logic [31:0]      evt_edge = '1;
  logic [16*RCW-1:0] rcfg = '0;
  logic [1:0]       auto_m = '0, req = '0, fb_mode = '0, grp_trip;
  logic             bus_fault = 0, cpu_stop = 0, cfg_def = 0, cfg_load = 0;
  logic             scan_rd = 0, ack = 0, irq, rise;
  logic [3:0]       fcode = 4'h0, code, chan;
  int               bad_count = 0;
  int               checked = 0;
  int               n;

  always #4 core_clk_in = ~core_clk_in;

  dio_field_model #(.NCH(16)) field (.core_clk_in(core_clk_in), .drive_in(drive),
    .short_in(short_m), .level_in(level), .raw_out(raw), .overload_out(ovl));

  dio_group_ctrl #(.REARM_CYC(RC), .FILT_MIN_CYC(3), .FILT_STEP_CYC(5)) dut (
    .core_clk_in(core_clk_in), .srst_in(srst_in), .raw_in(raw), .out_cmd_in(out_cmd),
    .overload_in(ovl), .rearm_auto_in(auto_m), .rearm_req_in(req),
    .bus_fault_in(bus_fault), .cpu_stop_in(cpu_stop), .fb_mode_in(fb_mode),
    .fb_val_in(fb_val), .cfg_default_in(cfg_def), .cfg_load_in(cfg_load),
    .filt_code_in(fcode), .latch_en_in(latch_en), .latch_rise_in(latch_rise),
    .scan_read_in(scan_rd), .evt_en_in(evt_en), .evt_edge_in(evt_edge),
    .evt_ack_in(ack), .reflex_en_in(rfx_en), .reflex_cfg_in(rcfg),
    .out_drive_out(drive), .tripped_out(trip), .grp_trip_out(grp_trip),
    .filt_out(filt), .latch_out(latch), .filt_code_out(code), .evt_irq_out(irq),
    .evt_chan_out(chan), .evt_rise_out(rise));

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checked++;
    if (seen !== exp) begin
      bad_count++;
      $display("mismatch %s expected %h seen %h", what, exp, seen);
    end
  endtask

  task automatic at_edge();
    @(posedge core_clk_in);
  endtask

  // settled sample one step after the edge
  task automatic tk(input int k = 1);
    repeat (k) begin
      @(posedge core_clk_in);
      #1;
    end
  endtask

  task automatic end_of_test();
    $display("checks %0d mismatches %0d", checked, bad_count);
    if (bad_count == 0 && checked > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask

  task automatic get_evt(input logic [3:0] ec, input logic er);
    for (n = 0; n < 80 && irq !== 1'b1; n++) tk();
    chk("evt_irq", irq, 1'b1);
    chk("evt_chan", chan, ec);
    chk("evt_rise", rise, er);
    at_edge();
    ack <= 1'b1;
    at_edge();
    ack <= 1'b0;
    #1;
    chk("evt_irq_drop", irq, 1'b0);
  endtask

  task automatic req_pulse();
    at_edge();
    req <= 2'b10;
    at_edge();
    req <= 2'b00;
    tk(3);
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic filter_test();
    chk("filt_code_rst", code, 4'h8);
    at_edge();
    // host keeps the filter at 3.5 ms or more
    fcode <= 4'h7;
    cfg_load <= 1'b1;
    at_edge();
    cfg_load <= 1'b0;
    tk(2);
    chk("filt_code", code, 4'h7);
    at_edge();
    level[6] <= 1'b1;
    tk(6);
    at_edge();
    level[6] <= 1'b0;
    tk(14);
    chk("short_pulse", filt[6], 1'b0);
    at_edge();
    level[6] <= 1'b1;
    for (n = 0; n < 60 && filt[6] !== 1'b1; n++) tk();
    chk("filt_delay", (n >= 35 && n <= 39), 1'b1);
    at_edge();
    level[6] <= 1'b0;
    cfg_def <= 1'b1;
    cfg_load <= 1'b1;
    fcode <= 4'hf;
    at_edge();
    cfg_def <= 1'b0;
    cfg_load <= 1'b0;
    tk(40);
    chk("filt_code_def", code, 4'h8);
    $display("filter test done");
  endtask

  task automatic latch_test();
    at_edge();
    latch_en <= 16'h0006;
    latch_rise <= 16'h0002;
    level[2] <= 1'b1;
    tk(45);
    at_edge();
    scan_rd <= 1'b1;
    at_edge();
    scan_rd <= 1'b0;
    tk();
    chk("latch_clr", latch, 16'h0);
    at_edge();
    level[1] <= 1'b1;
    level[2] <= 1'b0;
    tk(45);
    chk("latch_dir", latch, 16'h0006);
    at_edge();
    level[1] <= 1'b0;
    level[2] <= 1'b1;
    tk(45);
    chk("latch_hold", latch, 16'h0006);
    at_edge();
    scan_rd <= 1'b1;
    at_edge();
    scan_rd <= 1'b0;
    tk();
    chk("latch_read", latch, 16'h0);
    $display("latch test done");
  endtask

  task automatic event_test();
    at_edge();
    latch_en <= '0;
    evt_en <= 16'h0029;
    evt_edge <= 32'hfffff3bc;
    rfx_en <= 16'h0010;
    rcfg[4*RCW +: 8] <= 8'h02;
    at_edge();
    level[3] <= 1'b1;
    level[5] <= 1'b1;
    get_evt(4'h3, 1'b1);
    get_evt(4'h5, 1'b1);
    at_edge();
    level[3] <= 1'b0;
    level[5] <= 1'b0;
    get_evt(4'h3, 1'b0);
    tk(10);
    chk("no_fall_evt", irq, 1'b0);
    chk("reflex_low", drive[4], 1'b0);
    at_edge();
    level[0] <= 1'b1;
    get_evt(4'h0, 1'b1);
    tk(3);
    chk("reflex_high", drive[4], 1'b1);
    at_edge();
    level[0] <= 1'b0;
    rfx_en <= '0;
    evt_en <= '0;
    tk(50);
    $display("event test done");
  endtask

  task automatic rearm_auto_test();
    at_edge();
    auto_m <= 2'b01;
    out_cmd <= 16'h0006;
    short_m[1] <= 1'b1;
    for (n = 0; n < 10 && trip[1] !== 1'b1; n++) tk();
    chk("trip", trip, 16'h0002);
    chk("trip_off", drive, 16'h0004);
    chk("grp_trip", grp_trip, 2'b01);
    tk(RC + 5);
    chk("retrip", trip[1], 1'b1);
    at_edge();
    short_m[1] <= 1'b0;
    for (n = 0; n < RC + 5 && trip[1] !== 1'b0; n++) tk();
    chk("retry_time", (RC + 6 + n >= 2 * RC - 3 && RC + 6 + n <= 2 * RC + 4), 1'b1);
    tk();
    chk("rearm_drive", drive, 16'h0006);
    at_edge();
    out_cmd <= '0;
    $display("auto re-arm test done");
  endtask

  task automatic rearm_cmd_test();
    at_edge();
    out_cmd <= 16'h0300;
    short_m[9] <= 1'b1;
    for (n = 0; n < 10 && trip[9] !== 1'b1; n++) tk();
    at_edge();
    short_m[9] <= 1'b0;
    tk(RC + 5);
    chk("no_auto", trip, 16'h0200);
    req_pulse();
    chk("cmd_rearm", trip, 16'h0);
    chk("cmd_drive", drive, 16'h0300);
    at_edge();
    short_m[9] <= 1'b1;
    for (n = 0; n < 10 && trip[9] !== 1'b1; n++) tk();
    at_edge();
    short_m[9] <= 1'b0;
    req_pulse();
    chk("early_req", trip[9], 1'b1);
    tk(RC);
    req_pulse();
    chk("late_req", trip[9], 1'b0);
    at_edge();
    out_cmd <= '0;
    $display("commanded re-arm test done");
  endtask

  task automatic fallback_test();
    at_edge();
    out_cmd <= 16'ha55a;
    fb_val <= 16'h0f3c;
    fb_mode <= 2'b01;
    tk(3);
    at_edge();
    bus_fault <= 1'b1;
    out_cmd <= '0;
    tk(3);
    chk("fb_bus", drive, 16'ha53c);
    at_edge();
    bus_fault <= 1'b0;
    tk(3);
    chk("fb_exit", drive, 16'h0);
    at_edge();
    out_cmd <= 16'h5aa5;
    fb_mode <= 2'b10;
    tk(3);
    at_edge();
    cpu_stop <= 1'b1;
    out_cmd <= 16'hffff;
    tk(3);
    chk("fb_stop", drive, 16'h0fa5);
    at_edge();
    cpu_stop <= 1'b0;
    out_cmd <= '0;
    $display("fallback test done");
  endtask

  // ------------------------------------------------------------
  // sequence
  // ------------------------------------------------------------
  initial begin
    repeat (5) at_edge();
    srst_in <= 1'b0;
    tk();
    filter_test();
    latch_test();
    event_test();
    rearm_auto_test();
    rearm_cmd_test();
    fallback_test();
    end_of_test();
  end

  initial begin
    #60000;
    bad_count++;
    end_of_test();
  end
endmodule
